// [flash_guard_params.svh]
// Constants for the host-side controller of a parallel NOR flash with password
// protection and irreversible block locking.
// Assumes a 100 MHz clock and a flash with a 22-bit word address and 16-bit data.
//
// Functional notes
// - Password programming is only sent while password-command mode is entered.
// - The password is programmed before the mode-select bits choose password mode.
// - The password is tested through the global lock bit before password mode.
// - After a full password submission the host waits the verification time.
// - Lock flow: enter guard mode, program guard bits, exit, then lock; the controller accepts a lock without guard-bit programming.
// - Boot-area program or erase needs write-protect high; elsewhere either level.
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH

`define CLK_MHZ            100
`define T_WE_LOW_NS        50
`define T_READ_NS          70
`define T_RECOVER_NS       30
`define T_RESET_NS         500
`define T_PW_VERIFY_NS     2000
`define WE_LOW_CYC         8'((`T_WE_LOW_NS * `CLK_MHZ + 999) / 1000)
`define READ_CYC           8'((`T_READ_NS * `CLK_MHZ + 999) / 1000)
`define RECOVER_CYC        8'((`T_RECOVER_NS * `CLK_MHZ + 999) / 1000)
`define RESET_CYC          8'((`T_RESET_NS * `CLK_MHZ + 999) / 1000)
`define PW_VERIFY_CYC      8'((`T_PW_VERIFY_NS * `CLK_MHZ + 999) / 1000)

`define PW_WORDS           3'h4
`define BOOT_FIRST         22'h00_0000
`define BOOT_LAST          22'h00_7FFF
`define LOCK_STATUS_ADDR   22'h00_05FE
`define PW_MODE_BITS       2'h1
`define BAD_MODE_BITS      2'h0

`define REG_CTRL           8'h00
`define REG_ADDR           8'h04
`define REG_WDATA          8'h08
`define REG_RDATA          8'h0C
`define REG_STATUS         8'h10
`define REG_HOST_FLAGS     8'h14

`define CTRL_START         0
`define CTRL_WRITE         1
`define CTRL_WP_LEVEL      2
`define CTRL_PIN_RESET     3
`define CTRL_OP_LSB        4
`define HFLAG_PW_SET       0
`define HFLAG_PW_TESTED    1
`define HFLAG_GLOBAL_OPEN  2

`endif

// [flash_guard_pkg.sv]
// Types shared by the flash guard controller and its bus-cycle engine.
// Assumes flash_guard_params.svh supplies the numeric constants.
package flash_guard_pkg;

  typedef enum logic [3:0] {
    OP_PLAIN,
    OP_PW_ENTRY,
    OP_PW_EXIT,
    OP_PW_PROGRAM,
    OP_PW_READ,
    OP_PW_SUBMIT,
    OP_MODE_PROG,
    OP_GUARD_ENTRY,
    OP_GUARD_EXIT,
    OP_GUARD_PROG,
    OP_IRR_LOCK
  } op_t;

  typedef enum {
    ENG_IDLE,
    ENG_SETUP,
    ENG_STROBE,
    ENG_RECOVER,
    ENG_RESET
  } eng_state_t;

endpackage

// [flash_cycle_if.sv]
// Carrier between the controller and its single bus-cycle engine.
// Assumes both ends share mclk_in.
`timescale 1ns/1ns
`default_nettype none

interface flash_cycle_if;
  logic        start;
  logic        wr;
  logic        rst_req;
  logic        wp_level;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic [15:0] rdata;

  modport ctrl (output start, wr, rst_req, wp_level, addr, wdata,
                input busy, done, rdata);
  modport engine (input start, wr, rst_req, wp_level, addr, wdata,
                  output busy, done, rdata);
endinterface

`default_nettype wire

// [flash_cycle_engine.sv]
// One asynchronous flash bus cycle at a time: a write, a read or a reset pulse.
// Assumes the flash pins are sampled and driven synchronously to mclk_in.
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_params.svh"

module flash_cycle_engine (
  // Clock and reset
  input  wire logic   mclk_in,
  input  wire logic   reset_in,
  // Cycle requests
  flash_cycle_if.engine cyc,
  // Flash pins
  output logic        ce_n_out,
  output logic        oe_n_out,
  output logic        we_n_out,
  output logic        rst_n_out,
  output logic        wp_n_out,
  output logic [21:0] addr_out,
  output logic [15:0] dq_out,
  output logic        dq_oe_n_out,
  input  wire logic [15:0] dq_in
);
  import flash_guard_pkg::*;

  eng_state_t state;
  logic [7:0] cnt;
  logic       wr_q;
  wire        in_boot = (cyc.addr >= `BOOT_FIRST) && (cyc.addr <= `BOOT_LAST);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state       <= ENG_IDLE;
      cnt         <= 8'h00;
      wr_q        <= 1'b0;
      ce_n_out    <= 1'b1;
      oe_n_out    <= 1'b1;
      we_n_out    <= 1'b1;
      rst_n_out   <= 1'b1;
      wp_n_out    <= 1'b1;
      addr_out    <= 22'h00_0000;
      dq_out      <= 16'h0000;
      dq_oe_n_out <= 1'b1;
      cyc.busy    <= 1'b0;
      cyc.done    <= 1'b0;
      cyc.rdata   <= 16'h0000;
    end else begin
      cyc.done <= 1'b0;
      unique case (state)
        ENG_IDLE: begin
          if (cyc.start) begin
            cyc.busy <= 1'b1;
            wr_q     <= cyc.wr;
            addr_out <= cyc.addr;
            if (cyc.rst_req) begin
              rst_n_out <= 1'b0;
              cnt       <= `RESET_CYC;
              state     <= ENG_RESET;
            end else begin
              // Boot-area writes always raise write-protect; locked boot blocks
              // ignore the pin anyway, so raising it is never harmful.
              wp_n_out    <= (cyc.wr && in_boot) ? 1'b1 : cyc.wp_level;
              ce_n_out    <= 1'b0;
              dq_out      <= cyc.wdata;
              dq_oe_n_out <= !cyc.wr;
              state       <= ENG_SETUP;
            end
          end
        end
        ENG_SETUP: begin
          we_n_out <= !wr_q;
          oe_n_out <= wr_q;
          cnt      <= wr_q ? `WE_LOW_CYC : `READ_CYC;
          state    <= ENG_STROBE;
        end
        ENG_STROBE: begin
          if (cnt == 8'h01) begin
            if (!wr_q) begin
              cyc.rdata <= dq_in;
            end
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            cnt      <= `RECOVER_CYC;
            state    <= ENG_RECOVER;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ENG_RECOVER: begin
          // Data is released one cycle after the write strobe rises for hold time.
          ce_n_out    <= 1'b1;
          dq_oe_n_out <= 1'b1;
          if (cnt <= 8'h01) begin
            cyc.busy <= 1'b0;
            cyc.done <= 1'b1;
            state    <= ENG_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ENG_RESET: begin
          if (cnt == 8'h01) begin
            rst_n_out <= 1'b1;
            cnt       <= `RECOVER_CYC;
            state     <= ENG_RECOVER;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [flash_guard_ctrl.sv]
// Host controller for a NOR flash's password and irreversible-lock protection.
// Software issues single flash bus cycles through APB registers; the controller
// tracks the flash protection modes and refuses cycles that break their order.
// Assumes an APB master on mclk_in and a flash wired to the pin group below.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_params.svh"

module flash_guard_ctrl (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Flash pins
  output logic             ce_n_out,
  output logic             oe_n_out,
  output logic             we_n_out,
  output logic             rst_n_out,
  output logic             wp_n_out,
  output logic [21:0]      addr_out,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n_out,
  input  wire logic [15:0] dq_in
);
  import flash_guard_pkg::*;

  flash_cycle_if cyc ();

  // ----------------------------------------------------------------
  // Software-visible state, password word count and latched request
  // ----------------------------------------------------------------
  logic [21:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [2:0]  host_flags;
  logic        done_flag;
  logic        refused_flag;
  logic        pw_cmd_mode;
  logic        guard_mode;
  logic        pw_mode_chosen;
  logic        irr_locked;
  logic        lock_done_flag;
  logic [2:0]  pw_words;
  logic [7:0]  verify_cnt;
  op_t         op_q;
  logic        start_q;
  logic        wr_q;
  logic        rst_req_q;
  logic        wp_level_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access   = psel_in && penable_in && !pready_out;
  wire taken    = psel_in && penable_in && pready_out;
  wire wr_taken = taken && pwrite_in;
  wire mapped   = (paddr_in == `REG_CTRL) || (paddr_in == `REG_ADDR) ||
                  (paddr_in == `REG_WDATA) || (paddr_in == `REG_RDATA) ||
                  (paddr_in == `REG_STATUS) || (paddr_in == `REG_HOST_FLAGS);
  wire ctrl_wr  = wr_taken && (paddr_in == `REG_CTRL);
  wire go       = ctrl_wr && pwdata_in[`CTRL_START] && !cyc.busy && !start_q;
  wire [3:0] op_raw = pwdata_in[`CTRL_OP_LSB +: 4];
  wire op_t  op_new = op_t'(op_raw);
  wire       new_wr = pwdata_in[`CTRL_WRITE];

  wire [31:0] status_word = {23'h00_0000, lock_done_flag, irr_locked, pw_mode_chosen,
                             guard_mode, pw_cmd_mode, (verify_cnt != 8'h00),
                             refused_flag, done_flag, cyc.busy};
  wire [31:0] read_mux =
    (paddr_in == `REG_CTRL)       ? {28'h000_0000, op_q} :
    (paddr_in == `REG_ADDR)       ? {10'h000, addr_reg} :
    (paddr_in == `REG_WDATA)      ? {16'h0000, wdata_reg} :
    (paddr_in == `REG_RDATA)      ? {16'h0000, rdata_reg} :
    (paddr_in == `REG_STATUS)     ? status_word :
    (paddr_in == `REG_HOST_FLAGS) ? {29'h0000_0000, host_flags} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Order checks on the requested cycle
  // ----------------------------------------------------------------
  // The host mirrors the flash's own lockouts so that a refused cycle never
  // reaches the pins; the flash would ignore most of them anyway.
  wire verify_busy = (verify_cnt != 8'h00);
  wire pw_closed   = pw_mode_chosen || irr_locked;
  wire bad_pw_prog = (op_new == OP_PW_PROGRAM) && (!pw_cmd_mode || pw_closed);
  wire bad_pw_read = (op_new == OP_PW_READ) && !pw_cmd_mode;
  wire bad_submit  = (op_new == OP_PW_SUBMIT) &&
                     (!pw_cmd_mode || verify_busy || irr_locked);
  wire bad_pw_exit = (op_new == OP_PW_EXIT) && verify_busy;
  wire bad_mode    = (op_new == OP_MODE_PROG) &&
                     (!host_flags[`HFLAG_PW_SET] || !host_flags[`HFLAG_PW_TESTED] ||
                      wdata_reg[2:1] == `BAD_MODE_BITS || irr_locked);
  wire bad_guard   = (op_new == OP_GUARD_PROG) &&
                     (!guard_mode || !host_flags[`HFLAG_GLOBAL_OPEN] || irr_locked);
  wire bad_lock    = (op_new == OP_IRR_LOCK) &&
                     (guard_mode || irr_locked || !host_flags[`HFLAG_GLOBAL_OPEN]);
  wire refuse      = new_wr && (bad_pw_prog || bad_submit || bad_pw_exit || bad_mode ||
                     bad_guard || bad_lock) || (!new_wr && bad_pw_read);
  wire launch      = go && !refuse;

  // Lock status word read back in identification mode carries the done flag.
  wire lock_read_done = cyc.done && !wr_q && !rst_req_q && (op_q == OP_PLAIN) &&
                        (addr_reg == `LOCK_STATUS_ADDR);

  // ----------------------------------------------------------------
  // APB slave: one wait state, then the answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= access;
      pslverr_out <= access && !mapped;
      prdata_out  <= (access && !pwrite_in) ? read_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers and request launch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      addr_reg   <= 22'h00_0000;
      wdata_reg  <= 16'h0000;
      host_flags <= 3'h0;
      op_q       <= OP_PLAIN;
      start_q    <= 1'b0;
      wr_q       <= 1'b0;
      rst_req_q  <= 1'b0;
      wp_level_q <= 1'b1;
    end else begin
      start_q <= launch;
      if (wr_taken && paddr_in == `REG_ADDR) begin
        addr_reg <= pwdata_in[21:0];
      end
      if (wr_taken && paddr_in == `REG_WDATA) begin
        wdata_reg <= pwdata_in[15:0];
      end
      if (wr_taken && paddr_in == `REG_HOST_FLAGS) begin
        host_flags <= pwdata_in[2:0];
      end
      if (launch) begin
        op_q       <= op_new;
        wr_q       <= new_wr;
        rst_req_q  <= pwdata_in[`CTRL_PIN_RESET];
        wp_level_q <= pwdata_in[`CTRL_WP_LEVEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      done_flag      <= 1'b0;
      refused_flag   <= 1'b0;
      pw_cmd_mode    <= 1'b0;
      guard_mode     <= 1'b0;
      pw_mode_chosen <= 1'b0;
      irr_locked     <= 1'b0;
      lock_done_flag <= 1'b1;
      pw_words       <= 3'h0;
      verify_cnt     <= 8'h00;
      rdata_reg      <= 16'h0000;
    end else begin
      // A finishing cycle sets done even if software starts another at once.
      if (cyc.done) begin
        done_flag <= 1'b1;
      end else if (go) begin
        done_flag <= 1'b0;
      end
      if (go) begin
        refused_flag <= refuse;
      end
      if (verify_busy) begin
        verify_cnt <= verify_cnt - 8'h01;
      end
      if (cyc.done && !wr_q) begin
        // Password words read as all ones once password mode is chosen.
        rdata_reg <= (op_q == OP_PW_READ && pw_mode_chosen) ? 16'hFFFF : cyc.rdata;
      end
      if (lock_read_done) begin
        lock_done_flag <= cyc.rdata[0];
      end
      if (cyc.done && rst_req_q) begin
        pw_cmd_mode <= 1'b0;
        guard_mode  <= 1'b0;
        pw_words    <= 3'h0;
      end else if (cyc.done && wr_q) begin
        unique case (op_q)
          OP_PW_ENTRY: begin
            pw_cmd_mode <= 1'b1;
            pw_words    <= 3'h0;
          end
          OP_PW_EXIT: begin
            pw_cmd_mode <= 1'b0;
          end
          OP_PW_SUBMIT: begin
            if (pw_words == `PW_WORDS - 3'h1) begin
              pw_words   <= 3'h0;
              verify_cnt <= `PW_VERIFY_CYC;
            end else begin
              pw_words <= pw_words + 3'h1;
            end
          end
          OP_MODE_PROG: begin
            if (wdata_reg[2:1] == `PW_MODE_BITS) begin
              pw_mode_chosen <= 1'b1;
            end
          end
          OP_GUARD_ENTRY: begin
            guard_mode <= 1'b1;
          end
          OP_GUARD_EXIT: begin
            guard_mode <= 1'b0;
          end
          OP_IRR_LOCK: begin
            irr_locked     <= 1'b1;
            lock_done_flag <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign cyc.start    = start_q;
  assign cyc.wr       = wr_q;
  assign cyc.rst_req  = rst_req_q;
  assign cyc.wp_level = wp_level_q;
  assign cyc.addr     = addr_reg;
  assign cyc.wdata    = wdata_reg;

  flash_cycle_engine u_engine (
    .mclk_in     (mclk_in),
    .reset_in    (reset_in),
    .cyc         (cyc.engine),
    .ce_n_out    (ce_n_out),
    .oe_n_out    (oe_n_out),
    .we_n_out    (we_n_out),
    .rst_n_out   (rst_n_out),
    .wp_n_out    (wp_n_out),
    .addr_out    (addr_out),
    .dq_out      (dq_out),
    .dq_oe_n_out (dq_oe_n_out),
    .dq_in       (dq_in)
  );

endmodule

`default_nettype wire

// [flash_guard_ctrl_asserts.sv]
// Concurrent checks on the flash guard controller's bus and flash pins.
// Assumes it is bound to flash_guard_ctrl and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_params.svh"

module flash_guard_ctrl_asserts (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        ce_n_out,
  input wire logic        oe_n_out,
  input wire logic        we_n_out,
  input wire logic        rst_n_out,
  input wire logic        wp_n_out,
  input wire logic [21:0] addr_out,
  input wire logic        dq_oe_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // Bus and pin properties
  // ----------------------------------------------------------------
  apb_wait_a: assert property (psel_in && penable_in && !$past(penable_in) |->
    !pready_out ##1 pready_out) else $error("ready not on second access cycle");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside ready");
  no_contention_a: assert property (!dq_oe_n_out |-> oe_n_out && !ce_n_out)
    else $error("host drives data while flash may");
  strobe_excl_a: assert property (!we_n_out |-> oe_n_out && !ce_n_out)
    else $error("write strobe without select or with read");
  we_width_a: assert property ($fell(we_n_out) |=> !we_n_out[*4] ##1 we_n_out)
    else $error("write strobe width wrong");
  oe_width_a: assert property ($fell(oe_n_out) |=> !oe_n_out[*6] ##1 oe_n_out)
    else $error("read strobe width wrong");
  boot_wp_a: assert property (!we_n_out && addr_out <= `BOOT_LAST |-> wp_n_out)
    else $error("boot area write with write protect low");
  rst_width_a: assert property ($fell(rst_n_out) |-> ##49 !rst_n_out ##1 rst_n_out)
    else $error("flash reset width wrong");
endmodule

bind flash_guard_ctrl flash_guard_ctrl_asserts i_chk (.mclk_in, .reset_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .ce_n_out, .oe_n_out, .we_n_out,
  .rst_n_out, .wp_n_out, .addr_out, .dq_oe_n_out);
`default_nettype wire

// [flash_model.sv]
// Behavioural flash seen from its pins: a few password and data words.
// Assumes the controller strobes the pins synchronously to its own clock.
`timescale 1ns/1ns
`default_nettype none

module flash_model #(
  parameter int SLOW_NS = 60
) (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rst_n_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [15:0] dq_host_in,
  input  wire logic        dq_oe_n_in,
  output logic [15:0]      dq_out
);
  logic [15:0] mem [16];
  logic        drive;
  logic        ready;
  // ----------------------------------------------------------------
  // Storage and read drive
  // ----------------------------------------------------------------
  assign drive = !ce_n_in && !oe_n_in && we_n_in && rst_n_in;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // Cells only ever clear bits, so a later write can never restore a one.
  always @(posedge we_n_in)
    if (!ce_n_in && rst_n_in && !dq_oe_n_in) mem[addr_in[3:0]] &= dq_host_in;
  always @(drive) begin
    ready = 1'b0;
    if (drive) ready <= #(SLOW_NS) 1'b1;
  end
  // Released lines show the inverse so a stale sample never looks right.
  assign dq_out = (drive && ready) ? mem[addr_in[3:0]] : ~mem[addr_in[3:0]];
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the flash guard controller with a flash model.
// Assumes the controller's register map and refusal list as handed over.
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_params.svh"

module tb_top;
  import flash_guard_pkg::*;
  typedef struct packed {
    op_t         op;
    logic        wr;
    logic [3:0]  a;
    logic [15:0] d;
    logic        refused;
    logic [15:0] rd;
  } row_t;
  logic mclk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic ce_n_out, oe_n_out, we_n_out, rst_n_out, wp_n_out, dq_oe_n_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, q, stat;
  logic [21:0] addr_out;
  logic [15:0] dq_out, dq_in;
  logic        e;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  // The entry command and the second password program carry all ones because the model clears cell bits on every write.
  row_t rows [10] = '{
    '{OP_PW_PROGRAM, 1'b1, 4'h0, 16'h1234, 1'b1, 16'h0000},
    '{OP_PW_READ,    1'b0, 4'h0, 16'h0000, 1'b1, 16'h0000},
    '{OP_PW_ENTRY,   1'b1, 4'h0, 16'hFFFF, 1'b0, 16'h0000},
    '{OP_PW_PROGRAM, 1'b1, 4'h0, 16'h1234, 1'b0, 16'h0000},
    '{OP_PW_PROGRAM, 1'b1, 4'h0, 16'hFFFF, 1'b0, 16'h0000},
    '{OP_PW_READ,    1'b0, 4'h0, 16'h0000, 1'b0, 16'h1234},
    '{OP_PW_READ,    1'b0, 4'h1, 16'h0000, 1'b0, 16'hFFFF},
    '{OP_MODE_PROG,  1'b1, 4'h0, 16'h0002, 1'b1, 16'h0000},
    '{OP_IRR_LOCK,   1'b1, 4'h0, 16'h0000, 1'b1, 16'h0000},
    '{OP_GUARD_PROG, 1'b1, 4'h0, 16'h0000, 1'b1, 16'h0000}
  };

  flash_guard_ctrl i_dut (.mclk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ce_n_out, .oe_n_out,
    .we_n_out, .rst_n_out, .wp_n_out, .addr_out, .dq_out, .dq_oe_n_out, .dq_in);
  flash_model #(.SLOW_NS(60)) i_flash (.ce_n_in(ce_n_out), .oe_n_in(oe_n_out),
    .we_n_in(we_n_out), .rst_n_in(rst_n_out), .addr_in(addr_out), .dq_host_in(dq_out),
    .dq_oe_n_in(dq_oe_n_out), .dq_out(dq_in));

  always #5 mclk_in = ~mclk_in;
  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_st(input int k, input logic exp, input string what);
    chk({31'h0, stat[k]}, {31'h0, exp}, what);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Polls until the cycle ends or is refused; the bench timeout bounds it.
  task automatic run_cyc(input op_t op, input logic wr, input logic [21:0] a,
                         input logic [15:0] d, input logic pin_rst);
    apb(1'b1, `REG_ADDR, {10'h0, a});
    apb(1'b1, `REG_WDATA, {16'h0, d});
    apb(1'b1, `REG_CTRL, {24'h0, op, pin_rst, 1'b0, wr, 1'b1});
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      stat = q;
    end while (stat[0] !== 1'b0 || (stat[1] | stat[2]) !== 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {mclk_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    reset_in = 1'b1;
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(q, 32'h0000_0100, "status after reset");
    apb(1'b0, `REG_HOST_FLAGS, 32'h0);
    chk(q, 32'h0000_0000, "host flags after reset");
    apb(1'b1, 8'h18, 32'h0000_FFFF);
    chk({31'h0, e}, 32'h0000_0001, "unmapped write error");
    apb(1'b0, 8'h18, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000, "unmapped read");
    foreach (rows[i]) begin
      run_cyc(rows[i].op, rows[i].wr, {18'h0, rows[i].a}, rows[i].d, 1'b0);
      chk_st(2, rows[i].refused, "refused flag");
      if (!rows[i].wr && !rows[i].refused) begin
        apb(1'b0, `REG_RDATA, 32'h0);
        chk(q, {16'h0, rows[i].rd}, "password word");
      end
    end
    for (int w = 0; w < 4; w++) run_cyc(OP_PW_SUBMIT, 1'b1, 22'(w), 16'h1234, 1'b0);
    chk_st(3, 1'b1, "verify wait");
    run_cyc(OP_PW_SUBMIT, 1'b1, 22'h0, 16'h1234, 1'b0);
    chk_st(2, 1'b1, "submit during wait");
    run_cyc(OP_PW_EXIT, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(2, 1'b1, "exit during wait");
    repeat (210) @(posedge mclk_in);
    apb(1'b1, `REG_HOST_FLAGS, 32'h0000_0007);
    apb(1'b0, `REG_HOST_FLAGS, 32'h0);
    chk({31'h0, q[1]}, 32'h0000_0001, "password tested");
    run_cyc(OP_MODE_PROG, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(2, 1'b1, "both mode bits low");
    run_cyc(OP_MODE_PROG, 1'b1, 22'h0, 16'h0002, 1'b0);
    chk_st(6, 1'b1, "password mode chosen");
    run_cyc(OP_PW_READ, 1'b0, 22'h0, 16'h0000, 1'b0);
    apb(1'b0, `REG_RDATA, 32'h0);
    chk(q, 32'h0000_FFFF, "password hidden");
    run_cyc(OP_PLAIN, 1'b0, 22'h0, 16'h0000, 1'b1);
    chk_st(4, 1'b0, "pin reset leaves command mode");
    run_cyc(OP_PW_ENTRY, 1'b1, 22'h0, 16'h0000, 1'b0);
    run_cyc(OP_PW_PROGRAM, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(2, 1'b1, "program after mode chosen");
    run_cyc(OP_GUARD_ENTRY, 1'b1, 22'h0, 16'h0000, 1'b0);
    run_cyc(OP_IRR_LOCK, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(2, 1'b1, "lock inside guard mode");
    run_cyc(OP_PLAIN, 1'b0, `LOCK_STATUS_ADDR, 16'h0000, 1'b0);
    chk_st(8, 1'b1, "lock status not locked");
    run_cyc(OP_GUARD_EXIT, 1'b1, 22'h0, 16'h0000, 1'b0);
    run_cyc(OP_IRR_LOCK, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(7, 1'b1, "irreversible lock applied");
    chk_st(8, 1'b0, "lock done flag cleared");
    run_cyc(OP_IRR_LOCK, 1'b1, 22'h0, 16'h0000, 1'b0);
    chk_st(2, 1'b1, "second lock refused");
    run_cyc(OP_MODE_PROG, 1'b1, 22'h0, 16'h0002, 1'b0);
    chk_st(2, 1'b1, "mode bits after lock");
    stop_test();
  end
endmodule
`default_nettype wire
